// >>> hdl/eocr_elem.sv
/*
 * Relaying element end: a frame buffer and the address relay that acts
 * either as an intermediate element or as the terminal end.
 * Assumes the network end drives the link interface and a local maintenance
 * unit executes pulses on o_exec and feeds terminal-side upstream frames.
 */
// Behaviour
// - Downstream addresses 2..6 decrement, then forward
// - Downstream address 1 executes and answers upstream
// - Own answer overwrites next terminal answer upstream
// - After address 1, forward broadcast with hold
// - Upstream addresses 1..5 increment, then forward
// - Address in three slots, third is lsb
// - Address 0 passes untouched, no action
// - Broadcast executes and passes with address kept
// - Broadcast: neither terminal nor elements acknowledge; elements relay
// - Terminal executes only addresses 0 and 7
// - Terminal answers 1..6 with address 0 hold
// - Network numbers elements relatively, terminal zero
// - Network discovers chain by stepping hold probes
// - Shared functions reuse identical message codes
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Frame buffer
// ----------------------------------------------------------------------
module eocr_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    // Filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Draining side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW:0]      next_count;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    // Ready and valid are registered so the link sees clean flop outputs
    assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    assign o_out_data = mem[rd_ptr];

    // Storage, no reset needed on data
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            wr_ptr      <= push ? PW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
            rd_ptr      <= pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
            count       <= next_count;
            o_in_ready  <= next_count < (PW+1)'(DEPTH);
            o_out_valid <= next_count != '0;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Address relay
// ----------------------------------------------------------------------
module eocr_elem #(
    parameter int               MSG_W      = eocr_pkg::MSG_W,
    parameter logic [MSG_W-1:0] HOLD_MSG   = eocr_pkg::HOLD_CODE,
    parameter int               FIFO_DEPTH = eocr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    // Static mode: high for terminal end, low for intermediate element
    input  wire logic             i_nt_mode,
    // Network-facing link
    eocr_link_if.elem             link,
    // Downstream toward the terminal side
    output logic                  o_dn_valid,
    output logic            [2:0] o_dn_addr,
    output logic      [MSG_W-1:0] o_dn_msg,
    input  wire logic             i_dn_ready,
    // Upstream from the terminal side
    input  wire logic             i_up_valid,
    input  wire logic       [2:0] i_up_addr,
    input  wire logic [MSG_W-1:0] i_up_msg,
    output logic                  o_up_ready,
    // Local execution
    output logic                  o_exec,
    output logic      [MSG_W-1:0] o_exec_msg
);
    localparam int FW = 3 + MSG_W;

    logic             q_valid;
    logic [FW-1:0]    q_data;
    logic             q_in_ready;
    logic             take;
    logic             resp_pend;
    logic [MSG_W-1:0] resp_msg;
    logic             hold_pend;
    logic             in_valid;
    logic       [2:0] in_addr;
    logic [MSG_W-1:0] in_msg;
    logic             up_valid;
    logic       [2:0] up_addr;
    logic [MSG_W-1:0] up_msg;

    // Incoming multiframes wait here so a busy terminal side stalls the link
    eocr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clock     (i_clock),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (link.dn_valid),
        .i_in_data   ({eocr_pkg::addr_of(link.dn_addr_slot_first, link.dn_addr_slot_second,
                                         link.dn_addr_slot_third), link.dn_msg}),
        .o_in_ready  (q_in_ready),
        .o_out_valid (q_valid),
        .o_out_data  (q_data),
        .i_out_ready (take)
    );
    assign link.dn_ready = q_in_ready;

    // Downstream decode of the buffered head
    wire       [2:0] h_addr    = q_data[FW-1:MSG_W];
    wire [MSG_W-1:0] h_msg     = q_data[MSG_W-1:0];
    wire             h_zero    = h_addr == eocr_pkg::ADDR_NT;
    wire             h_bcast   = h_addr == eocr_pkg::ADDR_BCAST;
    wire             h_one     = h_addr == eocr_pkg::ADDR_FIRST;
    wire             h_dec     = h_addr >= eocr_pkg::ADDR_DN_LO && h_addr <= eocr_pkg::ADDR_DN_HI;
    wire             nt_hold   = i_nt_mode && !(h_zero || h_bcast);
    wire             dn_free   = !o_dn_valid || i_dn_ready;
    // A second address-1 frame waits until the first answer has gone out
    assign           take      = q_valid && (i_nt_mode ? !(nt_hold && hold_pend)
                                                       : dn_free && !(h_one && resp_pend));
    wire             exec_now  = take && (i_nt_mode ? (h_zero || h_bcast)
                                                    : (h_one || h_bcast));
    wire             resp_set  = take && !i_nt_mode && h_one;
    wire       [2:0] fwd_addr  = h_one ? eocr_pkg::ADDR_BCAST
                               : h_dec ? h_addr - 3'h1 : h_addr;
    wire [MSG_W-1:0] fwd_msg   = h_one ? HOLD_MSG : h_msg;

    // Upstream selection: terminal hold reply beats relayed frames
    wire             up_free   = !up_valid || link.up_ready;
    wire             emit_hold = hold_pend && up_free;
    wire             emit_usr  = !emit_hold && in_valid && up_free;
    wire             replace   = emit_usr && resp_pend && !i_nt_mode;
    wire             in_inc    = !i_nt_mode && in_addr >= eocr_pkg::ADDR_FIRST
                                 && in_addr <= eocr_pkg::ADDR_UP_HI;
    wire       [2:0] usr_addr  = replace ? eocr_pkg::ADDR_FIRST
                               : in_inc ? in_addr + 3'h1 : in_addr;
    wire [MSG_W-1:0] usr_msg   = replace ? resp_msg : in_msg;
    wire             next_in   = (in_valid && !emit_usr) || (i_up_valid && o_up_ready);

    assign link.up_valid           = up_valid;
    assign link.up_addr_slot_first  = up_addr[2];
    assign link.up_addr_slot_second = up_addr[1];
    assign link.up_addr_slot_third  = up_addr[0];
    assign link.up_msg             = up_msg;

    // Downstream output stage and execute pulse
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_dn_valid <= 1'b0;
            o_dn_addr  <= 3'h0;
            o_dn_msg   <= '0;
            o_exec     <= 1'b0;
            o_exec_msg <= '0;
        end else begin
            o_dn_valid <= (take && !i_nt_mode) || (o_dn_valid && !i_dn_ready);
            o_dn_addr  <= (take && !i_nt_mode) ? fwd_addr : o_dn_addr;
            o_dn_msg   <= (take && !i_nt_mode) ? fwd_msg : o_dn_msg;
            o_exec     <= exec_now;
            o_exec_msg <= exec_now ? h_msg : o_exec_msg;
        end
    end

    // Pending answers; a new set wins over the clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            resp_pend <= 1'b0;
            resp_msg  <= '0;
            hold_pend <= 1'b0;
        end else begin
            resp_pend <= resp_set || (resp_pend && !replace);
            resp_msg  <= resp_set ? h_msg : resp_msg;                                    // echo as answer
            hold_pend <= (take && nt_hold) || (hold_pend && !emit_hold);
        end
    end

    // Terminal-side input stage keeps o_up_ready a flop output
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            in_valid   <= 1'b0;
            in_addr    <= 3'h0;
            in_msg     <= '0;
            o_up_ready <= 1'b0;
        end else begin
            in_valid   <= next_in;
            in_addr    <= (i_up_valid && o_up_ready) ? i_up_addr : in_addr;
            in_msg     <= (i_up_valid && o_up_ready) ? i_up_msg : in_msg;
            o_up_ready <= !next_in;
        end
    end

    // Upstream output stage
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            up_valid <= 1'b0;
            up_addr  <= 3'h0;
            up_msg   <= '0;
        end else if (emit_hold) begin
            up_valid <= 1'b1;
            up_addr  <= eocr_pkg::ADDR_NT;
            up_msg   <= HOLD_MSG;
        end else if (emit_usr) begin
            up_valid <= 1'b1;
            up_addr  <= usr_addr;
            up_msg   <= usr_msg;
        end else if (link.up_ready) begin
            up_valid <= 1'b0;
        end
    end
endmodule

// >>> hdl/eocr_pkg.sv
/*
 * Shared constants for the maintenance-channel address relay: address codes,
 * message code of the hold state, buffer depth and discovery figures.
 * Assumes the address field travels as three serial slot bits per multiframe.
 */
package eocr_pkg;

    // ------------------------------------------------------------------
    // Address field
    // ------------------------------------------------------------------
    localparam int       ADDR_W      = 3;
    localparam int       MSG_W       = 8;
    localparam logic [2:0] ADDR_NT     = 3'h0;   // Terminal end, always zero
    localparam logic [2:0] ADDR_FIRST  = 3'h1;   // Element nearest the switch
    localparam logic [2:0] ADDR_DN_LO  = 3'h2;   // Lowest address decremented
    localparam logic [2:0] ADDR_DN_HI  = 3'h6;   // Highest address decremented
    localparam logic [2:0] ADDR_UP_HI  = 3'h5;   // Highest address incremented
    localparam logic [2:0] ADDR_BCAST  = 3'h7;   // Broadcast
    localparam logic [2:0] ADDR_MAXEL  = 3'h6;   // Most elements on a line

    // ------------------------------------------------------------------
    // Message codes and sizing
    // ------------------------------------------------------------------
    localparam logic [7:0] HOLD_CODE   = 8'h55;  // Default hold-state code
    localparam int       FIFO_DEPTH  = 8;
    localparam logic [1:0] DISC_MATCH  = 2'h3;   // Identical replies to stop

    // Slot order is first, second, third; the third slot is the lsb
    function automatic logic [2:0] addr_of(input logic first, input logic second, input logic third);
        return {first, second, third};
    endfunction

endpackage

// >>> hdl/eocr_link_if.sv
/*
 * Link between the network end and the relaying element: one downstream
 * and one upstream multiframe address field plus message, valid/ready each.
 * Assumes both ends run on the same clock; no clocking block.
 */
`timescale 1ns/1ps
interface eocr_link_if #(parameter int MSG_W = 8);

    // Downstream, network toward terminal
    logic             dn_valid;
    logic             dn_ready;
    logic             dn_addr_slot_first;
    logic             dn_addr_slot_second;
    logic             dn_addr_slot_third;
    logic [MSG_W-1:0] dn_msg;
    // Upstream, terminal toward network
    logic             up_valid;
    logic             up_ready;
    logic             up_addr_slot_first;
    logic             up_addr_slot_second;
    logic             up_addr_slot_third;
    logic [MSG_W-1:0] up_msg;

    modport net (
        output dn_valid, dn_addr_slot_first, dn_addr_slot_second, dn_addr_slot_third, dn_msg, up_ready,
        input  dn_ready, up_valid, up_addr_slot_first, up_addr_slot_second, up_addr_slot_third, up_msg
    );
    modport elem (
        input  dn_valid, dn_addr_slot_first, dn_addr_slot_second, dn_addr_slot_third, dn_msg, up_ready,
        output dn_ready, up_valid, up_addr_slot_first, up_addr_slot_second, up_addr_slot_third, up_msg
    );

endinterface

// >>> hdl/eocr_net.sv
/*
 * Network end: sends maintenance frames to relatively numbered elements,
 * hands every upstream frame to the user and runs configuration discovery.
 * Assumes the relaying element end sits on the far side of the link.
 */
`timescale 1ns/1ps
module eocr_net #(
    parameter int               MSG_W    = eocr_pkg::MSG_W,
    parameter logic [MSG_W-1:0] HOLD_MSG = eocr_pkg::HOLD_CODE
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    // Link toward the elements
    eocr_link_if.net              link,
    // Command request
    input  wire logic             i_cmd_valid,
    input  wire logic       [2:0] i_cmd_addr,
    input  wire logic [MSG_W-1:0] i_cmd_msg,
    output logic                  o_cmd_ready,
    // Discovery
    input  wire logic             i_disc_start,
    output logic                  o_disc_done,
    output logic            [2:0] o_elem_count,
    // Upstream frames
    output logic                  o_rsp_valid,
    output logic            [2:0] o_rsp_addr,
    output logic      [MSG_W-1:0] o_rsp_msg
);
    typedef enum logic [1:0] {
        EOCR_IDLE = 2'b00,
        EOCR_SEND = 2'b01,
        EOCR_WAIT = 2'b10
    } eocr_state_t;

    eocr_state_t      state;
    eocr_state_t      next_state;
    logic             dn_valid;
    logic       [2:0] dn_addr;
    logic [MSG_W-1:0] dn_msg;
    logic       [2:0] probe;
    logic       [1:0] match;
    logic             up_ready;

    // Request decode
    wire             dn_free   = !dn_valid || link.dn_ready;
    wire             cmd_take  = i_cmd_valid && o_cmd_ready;                 // caller gives element number
    wire             probe_go  = state == EOCR_SEND && dn_free;
    wire             up_take   = link.up_valid && up_ready;
    wire       [2:0] u_addr    = eocr_pkg::addr_of(link.up_addr_slot_first, link.up_addr_slot_second,
                                                   link.up_addr_slot_third);
    wire             u_hold0   = u_addr == eocr_pkg::ADDR_NT && link.up_msg == HOLD_MSG;
    // Three hold replies from address zero mean the probe passed the last element
    wire             found_end = state == EOCR_WAIT && up_take && u_hold0
                                 && match == eocr_pkg::DISC_MATCH - 2'h1;
    wire             elem_seen = state == EOCR_WAIT && up_take && u_addr != eocr_pkg::ADDR_NT;
    wire             last_el   = probe == eocr_pkg::ADDR_MAXEL;
    wire             next_dnv  = cmd_take || probe_go || (dn_valid && !link.dn_ready);

    assign link.dn_valid            = dn_valid;
    assign link.dn_addr_slot_first  = dn_addr[2];
    assign link.dn_addr_slot_second = dn_addr[1];
    assign link.dn_addr_slot_third  = dn_addr[0];
    assign link.dn_msg              = dn_msg;
    assign link.up_ready            = up_ready;

    // Discovery sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            EOCR_IDLE: next_state = (i_disc_start && !cmd_take) ? EOCR_SEND : EOCR_IDLE;
            EOCR_SEND: next_state = dn_free ? EOCR_WAIT : EOCR_SEND;
            EOCR_WAIT: next_state = found_end || (elem_seen && last_el) ? EOCR_IDLE
                                  : elem_seen ? EOCR_SEND : EOCR_WAIT;
            default:   next_state = EOCR_IDLE;
        endcase
    end

    // State, probe address and reply counting
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state <= EOCR_IDLE;
            probe <= eocr_pkg::ADDR_FIRST;
            match <= 2'h0;
        end else begin
            state <= next_state;
            probe <= (state == EOCR_IDLE) ? eocr_pkg::ADDR_FIRST
                   : (elem_seen && !last_el) ? probe + 3'h1 : probe;
            match <= (probe_go || elem_seen) ? 2'h0
                   : (state == EOCR_WAIT && up_take) ? (u_hold0 ? match + 2'h1 : 2'h0) : match;
        end
    end

    // Downstream frame stage, commands only while discovery is idle
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            dn_valid    <= 1'b0;
            dn_addr     <= 3'h0;
            dn_msg      <= '0;
            o_cmd_ready <= 1'b0;
        end else begin
            dn_valid    <= next_dnv;
            dn_addr     <= probe_go ? probe : cmd_take ? i_cmd_addr : dn_addr;
            dn_msg      <= probe_go ? HOLD_MSG : cmd_take ? i_cmd_msg : dn_msg;
            o_cmd_ready <= next_state == EOCR_IDLE && !next_dnv && !i_disc_start;
        end
    end

    // Upstream reporting; the network end never stalls replies
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            up_ready     <= 1'b0;
            o_rsp_valid  <= 1'b0;
            o_rsp_addr   <= 3'h0;
            o_rsp_msg    <= '0;
            o_disc_done  <= 1'b0;
            o_elem_count <= 3'h0;
        end else begin
            up_ready     <= 1'b1;
            o_rsp_valid  <= up_take;
            o_rsp_addr   <= up_take ? u_addr : o_rsp_addr;
            o_rsp_msg    <= up_take ? link.up_msg : o_rsp_msg;
            o_disc_done  <= found_end || (elem_seen && last_el);
            o_elem_count <= found_end ? probe - 3'h1 : (elem_seen && last_el) ? probe : o_elem_count;
        end
    end
endmodule

// >>> tb/eocr_link_sva.sv
/* Checker on the link between network end and element end.
   Assumes one clock, synchronous active-low reset, wired beside the link. */
`timescale 1ns/1ps
module eocr_link_sva (
    // Clock and reset
    input wire logic       i_clock,
    input wire logic       i_reset_n,
    // Downstream
    input wire logic       dn_valid,
    input wire logic       dn_ready,
    input wire logic       dn_addr_slot_first,
    input wire logic       dn_addr_slot_second,
    input wire logic       dn_addr_slot_third,
    input wire logic [7:0] dn_msg,
    // Upstream
    input wire logic       up_valid,
    input wire logic       up_ready,
    input wire logic [7:0] up_msg
);
    // ------------------------------------------------------------
    // Handshake and reset
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    property p_dn_valid_hold;
        dn_valid && !dn_ready |=> dn_valid;
    endproperty
    a_dn_valid_hold: assert property (p_dn_valid_hold) else $error("frame withdrawn");
    // Slots must not move while refused, or the address is torn
    property p_dn_data_hold;
        dn_valid && !dn_ready |=> $stable({dn_addr_slot_first, dn_addr_slot_second, dn_addr_slot_third, dn_msg});
    endproperty
    a_dn_data_hold: assert property (p_dn_data_hold) else $error("frame changed while refused");
    property p_up_taken;
        up_valid |-> up_ready;
    endproperty
    a_up_taken: assert property (p_up_taken) else $error("upstream frame not taken");
    property p_reset_quiet;
        $rose(i_reset_n) |-> !dn_valid && !up_valid && !up_ready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("link busy out of reset");
    property p_up_ready_on;
        i_reset_n && $past(i_reset_n) |-> up_ready;
    endproperty
    a_up_ready_on: assert property (p_up_ready_on) else $error("network end not ready");
    property p_dn_ready_rise;
        $rose(i_reset_n) |-> !dn_ready ##[1:3] dn_ready;
    endproperty
    a_dn_ready_rise: assert property (p_dn_ready_rise) else $error("buffer not ready after reset");
    // Ready only falls on a fill, never on its own
    property p_dn_fill;
        $fell(dn_ready) |-> $past(dn_valid);
    endproperty
    a_dn_fill: assert property (p_dn_fill) else $error("refusal without fill");
    property p_reset_data;
        $rose(i_reset_n) |-> dn_msg == 8'h00 && up_msg == 8'h00;
    endproperty
    a_reset_data: assert property (p_reset_data) else $error("message not cleared");

    c_full: cover property ($fell(dn_ready));
    c_stall: cover property (dn_valid && !dn_ready ##1 !dn_ready);
    c_hold: cover property (up_valid && up_msg == eocr_pkg::HOLD_CODE);
endmodule

// >>> tb/testbench.sv
/* Bench joining the network end and the element end through the link.
   Assumes the design package, link and modules are compiled first. */
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] HOLD = eocr_pkg::HOLD_CODE;
    logic       i_clock = 1'b0, i_reset_n = 1'b0, i_nt_mode = 1'b0, i_dn_ready = 1'b1;
    logic       i_up_valid = 1'b0, i_cmd_valid = 1'b0, i_disc_start = 1'b0;
    logic [2:0] i_up_addr = 3'h0, i_cmd_addr = 3'h0;
    logic [7:0] i_up_msg = 8'h00, i_cmd_msg = 8'h00;
    logic       o_dn_valid, o_up_ready, o_exec, o_cmd_ready, o_disc_done, o_rsp_valid;
    logic [2:0] o_dn_addr, o_elem_count, o_rsp_addr;
    logic [7:0] o_dn_msg, o_exec_msg, o_rsp_msg;
    int         n_mismatch = 0, tests_run = 0, n_exec = 0, cycles = 0, e0;

    eocr_link_if eocr_link_if_i ();
    eocr_net eocr_net_i (.i_clock, .i_reset_n, .link(eocr_link_if_i.net), .i_cmd_valid, .i_cmd_addr, .i_cmd_msg,
        .o_cmd_ready, .i_disc_start, .o_disc_done, .o_elem_count, .o_rsp_valid, .o_rsp_addr, .o_rsp_msg);
    eocr_elem eocr_elem_i (.i_clock, .i_reset_n, .i_nt_mode, .link(eocr_link_if_i.elem), .o_dn_valid, .o_dn_addr,
        .o_dn_msg, .i_dn_ready, .i_up_valid, .i_up_addr, .i_up_msg, .o_up_ready, .o_exec, .o_exec_msg);
    eocr_link_sva eocr_link_sva_i (.i_clock, .i_reset_n, .dn_valid(eocr_link_if_i.dn_valid),
        .dn_ready(eocr_link_if_i.dn_ready), .dn_addr_slot_first(eocr_link_if_i.dn_addr_slot_first),
        .dn_addr_slot_second(eocr_link_if_i.dn_addr_slot_second),
        .dn_addr_slot_third(eocr_link_if_i.dn_addr_slot_third), .dn_msg(eocr_link_if_i.dn_msg),
        .up_valid(eocr_link_if_i.up_valid), .up_ready(eocr_link_if_i.up_ready), .up_msg(eocr_link_if_i.up_msg));

    // Clock, execute counter and hang guard
    always #20 i_clock = ~i_clock;
    always @(negedge i_clock) n_exec += (o_exec === 1'b1);
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge i_clock);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reset_dut();
        i_reset_n = 1'b0;
        repeat (2) tick();
        i_reset_n = 1'b1;
        repeat (2) tick();
    endtask
    // Held until the edge that sees ready, then a gap cycle
    task automatic send_cmd(input logic [2:0] a, input logic [7:0] m);
        {i_cmd_valid, i_cmd_addr, i_cmd_msg} = {1'b1, a, m};
        while (o_cmd_ready !== 1'b1) tick();
        tick();
        i_cmd_valid = 1'b0;
        tick();
    endtask
    task automatic send_up(input logic [2:0] a, input logic [7:0] m);
        {i_up_valid, i_up_addr, i_up_msg} = {1'b1, a, m};
        while (o_up_ready !== 1'b1) tick();
        tick();
        i_up_valid = 1'b0;
        tick();
    endtask
    task automatic expect_dn(input logic [2:0] a, input logic [7:0] m);
        while (o_dn_valid !== 1'b1 || i_dn_ready !== 1'b1) tick();
        chk("dn_addr", {5'h00, a}, {5'h00, o_dn_addr});
        chk("dn_msg", m, o_dn_msg);
        tick();
    endtask
    task automatic expect_exec(input logic [7:0] m);
        while (o_exec !== 1'b1) tick();
        chk("exec_msg", m, o_exec_msg);
        tick();
    endtask
    task automatic expect_rsp(input logic [2:0] a, input logic [7:0] m);
        while (o_rsp_valid !== 1'b1) tick();
        chk("rsp_addr", {5'h00, a}, {5'h00, o_rsp_addr});
        chk("rsp_msg", m, o_rsp_msg);
        tick();
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        reset_dut();
        e0 = n_exec;
        send_cmd(3'h0, 8'h12);
        expect_dn(3'h0, 8'h12);
        for (int a = 2; a < 7; a++) begin
            send_cmd(3'(a), 8'h30);
            expect_dn(3'(a - 1), 8'h30);
        end
        chk("exec_count", 8'h00, 8'(n_exec - e0));
        send_cmd(3'h7, 8'h3C);
        fork
            expect_exec(8'h3C);
            expect_dn(3'h7, 8'h3C);
        join
        // Broadcast must not arm an answer: address 0 comes back untouched
        for (int a = 0; a < 8; a++) begin
            fork
                send_up(3'(a), 8'h90);
                expect_rsp(3'(a + (a >= 1 && a <= 5)), 8'h90);
            join
        end
        send_cmd(3'h1, 8'hA5);
        fork
            expect_exec(8'hA5);
            expect_dn(3'h7, HOLD);
        join
        fork
            send_up(3'h0, 8'h99);
            expect_rsp(3'h1, 8'hA5);
        join
        // Far side stalls until the buffer refuses, then drains in order
        i_dn_ready = 1'b0;
        fork
            for (int k = 0; k < 14; k++) send_cmd(3'h0, 8'(k));
            begin
                repeat (60) tick();
                chk("dn_ready", 8'h00, {7'h00, eocr_link_if_i.dn_ready});
                i_dn_ready = 1'b1;
                for (int k = 0; k < 14; k++) expect_dn(3'h0, 8'(k));
            end
        join
        i_disc_start = 1'b1;
        tick();
        i_disc_start = 1'b0;
        expect_dn(3'h7, HOLD);
        send_up(3'h0, HOLD);
        expect_dn(3'h1, HOLD);
        repeat (3) send_up(3'h0, HOLD);
        while (o_disc_done !== 1'b1) tick();
        chk("elem_count", 8'h01, {5'h00, o_elem_count});
        i_nt_mode = 1'b1;
        reset_dut();
        send_cmd(3'h0, 8'h21);
        expect_exec(8'h21);
        send_cmd(3'h7, 8'h42);
        expect_exec(8'h42);
        e0 = n_exec;
        for (int a = 1; a < 7; a++) begin
            send_cmd(3'(a), 8'h77);
            expect_rsp(3'h0, HOLD);
        end
        chk("nt_exec", 8'h00, 8'(n_exec - e0));
        end_of_test();
    end
endmodule
